/* File: design/tmr_timer8.sv */
// Top: 8-bit timer/counter with one compare unit and register port
`timescale 1ns/1ps
`default_nettype none

module tmr_timer8 (
	input wire logic SYS_CLK_I, // 25 MHz clock
	input wire logic RESET_N_I, // Async reset, active low
	input wire logic [2:0] ADDR_I, // Register address
	input wire logic [7:0] WDATA_I, // Write data
	input wire logic WR_I, // Write strobe
	input wire logic RD_I, // Read strobe
	output logic [7:0] RDATA_O, // Read data, cycle after strobe
	input wire logic EXT_COUNT_PIN_I, // External count pin
	input wire logic GLOBAL_IRQ_EN_I, // Global interrupt enable from CPU status
	input wire logic OVF_IRQ_ACK_I, // Overflow interrupt serviced
	input wire logic CMP_IRQ_ACK_I, // Compare interrupt serviced
	output logic OVF_IRQ_O, // Overflow interrupt request
	output logic CMP_IRQ_O, // Compare interrupt request
	output logic COMPARE_OUTPUT_O, // Compare output pin value
	output logic COMPARE_OUTPUT_EN_O // Port override active
);

	// ==========================================================
	// Registers
	tmr_pkg::tmr_bus_req_t req;
	tmr_pkg::tmr_ctrl_t ctrl;
	logic [7:0] control_reg;
	logic [7:0] counter_value_reg;
	logic [7:0] compare_value_reg;
	logic [7:0] compare_buffer_reg;
	logic [1:0] irq_mask_reg;
	logic overflow_flag_reg;
	logic compare_flag_reg;
	logic count_down_reg;
	logic block_match_reg;
	logic tick;
	logic oc;
	logic is_pwm;
	logic match;
	logic match_ok;
	logic at_top;
	logic wr_counter;
	logic wr_compare;
	logic wr_flags;
	logic force_strobe;
	logic [7:0] counter_next;
	logic count_down_next;
	logic ovf_event;
	logic [7:0] rdata_next;

	assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
	assign ctrl = '{com: control_reg[tmr_pkg::CTL_COM_LSB +: 2],
		cs: control_reg[tmr_pkg::CTL_CS_LSB +: 3],
		wgm: control_reg[tmr_pkg::CTL_WGM_LSB +: 2]};

	assign is_pwm = (ctrl.wgm == tmr_pkg::WGM_FAST_PWM) || (ctrl.wgm == tmr_pkg::WGM_PHASE_PWM);
	assign wr_counter = req.wr && (req.addr == tmr_pkg::ADDR_COUNTER);
	assign wr_compare = req.wr && (req.addr == tmr_pkg::ADDR_COMPARE);
	assign wr_flags = req.wr && (req.addr == tmr_pkg::ADDR_FLAGS);
	assign force_strobe = req.wr && (req.addr == tmr_pkg::ADDR_FORCE)
		&& req.wdata[tmr_pkg::FORCE_BIT] && !is_pwm;

	// ==========================================================
	// Clock select and comparator
	tmr_clock_select #(
		.PRE_W(tmr_pkg::PRESCALE_WIDTH)
	) u_clock_select (
		.clk_i(SYS_CLK_I),
		.reset_n_i(RESET_N_I),
		.cs_i(ctrl.cs),
		.ext_pin_i(EXT_COUNT_PIN_I),
		.tick_o(tick)
	);

	assign match = (counter_value_reg == compare_value_reg);
	assign match_ok = match && !block_match_reg;

	always_comb begin
		case (ctrl.wgm)
			tmr_pkg::WGM_CLEAR_ON_MATCH: at_top = match;
			default: at_top = (counter_value_reg == tmr_pkg::MAX_VALUE);
		endcase
	end

	// ==========================================================
	// Control and mask registers
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			control_reg <= tmr_pkg::CONTROL_RESET;
		end else if (req.wr && (req.addr == tmr_pkg::ADDR_CONTROL)) begin
			control_reg <= req.wdata;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			irq_mask_reg <= 2'h0;
		end else if (req.wr && (req.addr == tmr_pkg::ADDR_MASK)) begin
			irq_mask_reg <= req.wdata[1:0];
		end
	end

	// ==========================================================
	// Counter unit
	always_comb begin
		counter_next = counter_value_reg;
		count_down_next = count_down_reg;
		ovf_event = 1'b0;
		case (ctrl.wgm)
			tmr_pkg::WGM_NORMAL: begin
				counter_next = counter_value_reg + 8'h01;
				count_down_next = 1'b0;
				ovf_event = (counter_value_reg == tmr_pkg::MAX_VALUE);
			end
			tmr_pkg::WGM_CLEAR_ON_MATCH: begin
				count_down_next = 1'b0;
				ovf_event = (counter_value_reg == tmr_pkg::MAX_VALUE) && !match_ok;
				if (match_ok) begin
					counter_next = tmr_pkg::BOTTOM_VALUE;
				end else begin
					counter_next = counter_value_reg + 8'h01;
				end
			end
			tmr_pkg::WGM_FAST_PWM: begin
				count_down_next = 1'b0;
				ovf_event = at_top;
				counter_next = at_top ? tmr_pkg::BOTTOM_VALUE : counter_value_reg + 8'h01;
			end
			default: begin
				if (!count_down_reg && at_top) begin
					count_down_next = 1'b1;
					counter_next = counter_value_reg - 8'h01;
				end else if (count_down_reg && (counter_value_reg == tmr_pkg::BOTTOM_VALUE)) begin
					count_down_next = 1'b0;
					counter_next = counter_value_reg + 8'h01;
					ovf_event = 1'b1;
				end else if (count_down_reg) begin
					counter_next = counter_value_reg - 8'h01;
				end else begin
					counter_next = counter_value_reg + 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			counter_value_reg <= tmr_pkg::COUNTER_RESET;
		end else if (wr_counter) begin
			counter_value_reg <= req.wdata;
		end else if (tick) begin
			counter_value_reg <= counter_next;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			count_down_reg <= 1'b0;
		end else if (tick) begin
			count_down_reg <= count_down_next;
		end
	end

	// Block lasts until the next tick has passed
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			block_match_reg <= 1'b0;
		end else if (wr_counter) begin
			block_match_reg <= 1'b1;
		end else if (tick) begin
			block_match_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Compare value and buffer
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			compare_buffer_reg <= tmr_pkg::COMPARE_RESET;
		end else if (wr_compare) begin
			compare_buffer_reg <= req.wdata;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			compare_value_reg <= tmr_pkg::COMPARE_RESET;
		end else if (!is_pwm) begin
			if (wr_compare) begin
				compare_value_reg <= req.wdata;
			end
		end else if (tick && (ctrl.wgm == tmr_pkg::WGM_FAST_PWM) && at_top) begin
			compare_value_reg <= compare_buffer_reg;
		end else if (tick && (ctrl.wgm == tmr_pkg::WGM_PHASE_PWM) && !count_down_reg && at_top) begin
			compare_value_reg <= compare_buffer_reg;
		end
	end

	// ==========================================================
	// Flags, set wins over clear
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			overflow_flag_reg <= 1'b0;
		end else if (tick && ovf_event && !wr_counter) begin
			overflow_flag_reg <= 1'b1;
		end else if (OVF_IRQ_ACK_I || (wr_flags && req.wdata[tmr_pkg::FLAG_OVF_BIT])) begin
			overflow_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			compare_flag_reg <= 1'b0;
		end else if (tick && match_ok && !wr_counter) begin
			compare_flag_reg <= 1'b1;
		end else if (CMP_IRQ_ACK_I || (wr_flags && req.wdata[tmr_pkg::FLAG_CMP_BIT])) begin
			compare_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			OVF_IRQ_O <= 1'b0;
			CMP_IRQ_O <= 1'b0;
		end else begin
			OVF_IRQ_O <= overflow_flag_reg && irq_mask_reg[0] && GLOBAL_IRQ_EN_I;
			CMP_IRQ_O <= compare_flag_reg && irq_mask_reg[1] && GLOBAL_IRQ_EN_I;
		end
	end

	// ==========================================================
	// Waveform generator and pin
	tmr_wavegen u_wavegen (
		.clk_i(SYS_CLK_I),
		.reset_n_i(RESET_N_I),
		.tick_i(tick && !wr_counter),
		.match_i(match_ok),
		.force_i(force_strobe),
		.at_bottom_i(at_top),
		.up_i(!count_down_reg),
		.wgm_i(ctrl.wgm),
		.com_i(ctrl.com),
		.oc_o(oc)
	);

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			COMPARE_OUTPUT_O <= 1'b0;
			COMPARE_OUTPUT_EN_O <= 1'b0;
		end else begin
			COMPARE_OUTPUT_O <= oc;
			COMPARE_OUTPUT_EN_O <= (ctrl.com != tmr_pkg::COM_NONE);
		end
	end

	// ==========================================================
	// Read port
	always_comb begin
		if (req.addr == tmr_pkg::ADDR_CONTROL) begin
			rdata_next = control_reg;
		end else if (req.addr == tmr_pkg::ADDR_COUNTER) begin
			rdata_next = counter_value_reg;
		end else if (req.addr == tmr_pkg::ADDR_COMPARE) begin
			rdata_next = is_pwm ? compare_buffer_reg : compare_value_reg;
		end else if (req.addr == tmr_pkg::ADDR_FLAGS) begin
			rdata_next = {6'h00, compare_flag_reg, overflow_flag_reg};
		end else if (req.addr == tmr_pkg::ADDR_MASK) begin
			rdata_next = {6'h00, irq_mask_reg};
		end else begin
			rdata_next = 8'h00;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			RDATA_O <= 8'h00;
		end else if (req.rd) begin
			RDATA_O <= rdata_next;
		end else begin
			RDATA_O <= 8'h00;
		end
	end

endmodule // tmr_timer8

`default_nettype wire

/* File: design/tmr_pkg.sv */
// Package: register map, field layout, modes and clock-select codes of the timer
package tmr_pkg;

	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_COUNTER = 3'h1;
	localparam logic [2:0] ADDR_COMPARE = 3'h2;
	localparam logic [2:0] ADDR_FLAGS = 3'h3;
	localparam logic [2:0] ADDR_MASK = 3'h4;
	localparam logic [2:0] ADDR_FORCE = 3'h5;

	localparam int CTL_WGM_LSB = 0;
	localparam int CTL_CS_LSB = 2;
	localparam int CTL_COM_LSB = 5;
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;
	localparam int FORCE_BIT = 0;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] COUNTER_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	localparam logic [7:0] BOTTOM_VALUE = 8'h00;
	localparam logic [7:0] MAX_VALUE = 8'hFF;

	localparam logic [1:0] WGM_NORMAL = 2'h0;
	localparam logic [1:0] WGM_PHASE_PWM = 2'h1;
	localparam logic [1:0] WGM_CLEAR_ON_MATCH = 2'h2;
	localparam logic [1:0] WGM_FAST_PWM = 2'h3;

	localparam logic [1:0] COM_NONE = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;

	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	localparam int PRESCALE_WIDTH = 10;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tmr_bus_req_t;

	typedef struct packed {
		logic [1:0] com;
		logic [2:0] cs;
		logic [1:0] wgm;
	} tmr_ctrl_t;

endpackage

/* File: design/tmr_clock_select.sv */
// Clock select: prescaler taps and synchronised external edge into one tick
`timescale 1ns/1ps
`default_nettype none

module tmr_clock_select #(
	parameter int PRE_W = tmr_pkg::PRESCALE_WIDTH
) (
	input wire logic clk_i, // System clock
	input wire logic reset_n_i, // Async reset, active low
	input wire logic [2:0] cs_i, // Clock select field
	input wire logic ext_pin_i, // External count pin, asynchronous
	output logic tick_o // One-cycle timer tick
);

	// ==========================================================
	// Prescaler and pin synchroniser
	logic [PRE_W-1:0] pre_reg;
	logic [2:0] ext_sync_reg;
	logic tick_next;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pre_reg <= '0;
		end else if (cs_i == tmr_pkg::CS_STOP) begin
			pre_reg <= '0;
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	// Stage 0 feeds only stage 1; edges are read from stages 1 and 2
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_sync_reg <= 3'h0;
		end else begin
			ext_sync_reg <= {ext_sync_reg[1:0], ext_pin_i};
		end
	end

	// ==========================================================
	// Tick selection
	always_comb begin
		case (cs_i)
			tmr_pkg::CS_DIV1: tick_next = 1'b1;
			tmr_pkg::CS_DIV8: tick_next = (pre_reg[2:0] == 3'h7);
			tmr_pkg::CS_DIV64: tick_next = (pre_reg[5:0] == 6'h3F);
			tmr_pkg::CS_DIV256: tick_next = (pre_reg[7:0] == 8'hFF);
			tmr_pkg::CS_DIV1024: tick_next = (pre_reg == '1);
			tmr_pkg::CS_EXT_FALL: tick_next = ext_sync_reg[2] & ~ext_sync_reg[1];
			tmr_pkg::CS_EXT_RISE: tick_next = ~ext_sync_reg[2] & ext_sync_reg[1];
			default: tick_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= tick_next;
		end
	end

endmodule // tmr_clock_select

`default_nettype wire

/* File: design/tmr_wavegen.sv */
// Waveform generator: holds the internal compare output state
`timescale 1ns/1ps
`default_nettype none

module tmr_wavegen (
	input wire logic clk_i, // System clock
	input wire logic reset_n_i, // Async reset, active low
	input wire logic tick_i, // Timer tick
	input wire logic match_i, // Unblocked compare match this tick
	input wire logic force_i, // Force-compare strobe
	input wire logic at_bottom_i, // Counter at top in fast PWM, wraps to bottom this tick
	input wire logic up_i, // Counting upward
	input wire logic [1:0] wgm_i, // Waveform mode
	input wire logic [1:0] com_i, // Compare output action
	output logic oc_o // Internal compare output state
);

	// ==========================================================
	// Output state update
	logic is_pwm;

	assign is_pwm = (wgm_i == tmr_pkg::WGM_FAST_PWM) || (wgm_i == tmr_pkg::WGM_PHASE_PWM);

	// State is never cleared on a mode change
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			oc_o <= 1'b0;
		end else if (com_i == tmr_pkg::COM_NONE) begin
			oc_o <= oc_o;
		end else if (!is_pwm) begin
			if ((tick_i && match_i) || force_i) begin
				case (com_i)
					tmr_pkg::COM_TOGGLE: oc_o <= ~oc_o;
					tmr_pkg::COM_CLEAR: oc_o <= 1'b0;
					default: oc_o <= 1'b1;
				endcase
			end
		end else if (tick_i && com_i[1]) begin
			if (wgm_i == tmr_pkg::WGM_FAST_PWM) begin
				if (match_i) begin
					oc_o <= com_i[0];
				end else if (at_bottom_i) begin
					oc_o <= ~com_i[0];
				end
			end else if (match_i) begin
				oc_o <= up_i ? com_i[0] : ~com_i[0];
			end
		end
	end

endmodule // tmr_wavegen

`default_nettype wire

/* File: verif/tmr_timer8_checker.sv */
// Checker: port-level properties of the timer top
`timescale 1ns/1ps
`default_nettype none

module tmr_timer8_checker (
	input wire logic SYS_CLK_I, // Clock
	input wire logic RESET_N_I, // Reset, active low
	input wire logic [2:0] ADDR_I, // Address
	input wire logic [7:0] WDATA_I, // Write data
	input wire logic WR_I, // Write strobe
	input wire logic RD_I, // Read strobe
	input wire logic [7:0] RDATA_O, // Read data
	input wire logic GLOBAL_IRQ_EN_I, // Global enable
	input wire logic OVF_IRQ_O, // Overflow request
	input wire logic CMP_IRQ_O, // Compare request
	input wire logic COMPARE_OUTPUT_EN_O // Port override
);
	// ==========
	// Shadows of clock select and mask, seen from the bus
	logic [2:0] cs_reg;
	logic [1:0] mask_reg;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			cs_reg <= tmr_pkg::CS_STOP;
		end else if (WR_I && ADDR_I == tmr_pkg::ADDR_CONTROL) begin
			cs_reg <= WDATA_I[4:2];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			mask_reg <= 2'h0;
		end else if (WR_I && ADDR_I == tmr_pkg::ADDR_MASK) begin
			mask_reg <= WDATA_I[1:0];
		end
	end

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	// ==========
	// Properties
	rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
		else $error("read data outside read cycle");
	unmapped_read_a: assert property (RD_I && ADDR_I > tmr_pkg::ADDR_FORCE |=> RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	ctl_readback_a: assert property ((WR_I && ADDR_I == tmr_pkg::ADDR_CONTROL) ##1 !WR_I
		##1 (RD_I && ADDR_I == tmr_pkg::ADDR_CONTROL) |=> RDATA_O[6:0] == $past(WDATA_I[6:0], 3))
		else $error("control readback wrong");
	cnt_readback_a: assert property ((WR_I && ADDR_I == tmr_pkg::ADDR_COUNTER && cs_reg == 3'h0)
		##1 !WR_I ##1 (RD_I && ADDR_I == tmr_pkg::ADDR_COUNTER) |=> RDATA_O == $past(WDATA_I, 3))
		else $error("stopped counter readback wrong");
	cmp_readback_a: assert property ((WR_I && ADDR_I == tmr_pkg::ADDR_COMPARE) ##1 !WR_I
		##1 (RD_I && ADDR_I == tmr_pkg::ADDR_COMPARE) |=> RDATA_O == $past(WDATA_I, 3))
		else $error("compare readback wrong");
	cmp_global_a: assert property (!$past(GLOBAL_IRQ_EN_I) |-> !CMP_IRQ_O)
		else $error("compare request without global enable");
	cmp_mask_a: assert property (CMP_IRQ_O |-> $past(mask_reg[1]))
		else $error("compare request while masked");
	ovf_gate_a: assert property (OVF_IRQ_O |-> $past(GLOBAL_IRQ_EN_I) && $past(mask_reg[0]))
		else $error("overflow request not gated");
	oe_action_a: assert property ((WR_I && ADDR_I == tmr_pkg::ADDR_CONTROL) ##1 !WR_I
		|=> COMPARE_OUTPUT_EN_O == (|$past(WDATA_I[6:5], 2)))
		else $error("override not following action bits");

	cmp_irq_c: cover property ($rose(CMP_IRQ_O));
	ovf_irq_c: cover property ($rose(OVF_IRQ_O));
	oe_on_c: cover property ($rose(COMPARE_OUTPUT_EN_O));
endmodule // tmr_timer8_checker

bind tmr_timer8 tmr_timer8_checker CHK (.SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I),
	.ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
	.GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .OVF_IRQ_O(OVF_IRQ_O), .CMP_IRQ_O(CMP_IRQ_O),
	.COMPARE_OUTPUT_EN_O(COMPARE_OUTPUT_EN_O));

`default_nettype wire

/* File: verif/tmr_host_model.sv */
// Host model: register bus master and interrupt service
`timescale 1ns/1ps
`default_nettype none

module tmr_host_model #(
	parameter int ACK_DELAY = 4
) (
	input wire logic clk_i, // System clock
	input wire logic service_en_i, // Service pending requests
	input wire logic ovf_irq_i, // Overflow request
	input wire logic cmp_irq_i, // Compare request
	input wire logic [7:0] rdata_i, // Read data
	output var tmr_pkg::tmr_bus_req_t req_o, // Bus request
	output logic ovf_ack_o, // Overflow serviced
	output logic cmp_ack_o // Compare serviced
);
	int wait_cnt;

	initial begin
		req_o = '0;
		ovf_ack_o = 1'b0;
		cmp_ack_o = 1'b0;
		wait_cnt = 0;
	end

	// Service after a delay; request lags the flag, so back off after an ack
	always @(posedge clk_i) begin
		ovf_ack_o <= 1'b0;
		cmp_ack_o <= 1'b0;
		if (service_en_i && (ovf_irq_i || cmp_irq_i)) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt == ACK_DELAY) begin
				cmp_ack_o <= cmp_irq_i;
				ovf_ack_o <= !cmp_irq_i && ovf_irq_i;
				wait_cnt <= -2;
			end
		end else begin
			wait_cnt <= 0;
		end
	end

	task automatic wr_reg(input logic [2:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		req_o.addr <= addr;
		req_o.wdata <= data;
		req_o.wr <= 1'b1;
		@(posedge clk_i);
		req_o.wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] addr, output logic [7:0] data);
		@(posedge clk_i);
		req_o.addr <= addr;
		req_o.rd <= 1'b1;
		@(posedge clk_i);
		req_o.rd <= 1'b0;
		// Read data stand only until the next rising edge, so take them mid-cycle
		@(negedge clk_i);
		data = rdata_i;
	endtask
endmodule // tmr_host_model

`default_nettype wire

/* File: verif/tmr_timer8_tb_top.sv */
// Testbench: scenarios for the 8-bit timer with compare unit
`timescale 1ns/1ps
`default_nettype none

module tmr_timer8_tb_top;
	logic clk;
	logic reset_n;
	logic ext_pin;
	logic global_en;
	logic service_en;
	tmr_pkg::tmr_bus_req_t req;
	logic [7:0] rdata;
	logic ovf_ack, cmp_ack, ovf_irq, cmp_irq, oc_out, oc_en;
	int failures = 0;
	int cmp_count = 0;

	tmr_timer8 DUT (.SYS_CLK_I(clk), .RESET_N_I(reset_n), .ADDR_I(req.addr),
		.WDATA_I(req.wdata), .WR_I(req.wr), .RD_I(req.rd), .RDATA_O(rdata),
		.EXT_COUNT_PIN_I(ext_pin), .GLOBAL_IRQ_EN_I(global_en), .OVF_IRQ_ACK_I(ovf_ack),
		.CMP_IRQ_ACK_I(cmp_ack), .OVF_IRQ_O(ovf_irq), .CMP_IRQ_O(cmp_irq),
		.COMPARE_OUTPUT_O(oc_out), .COMPARE_OUTPUT_EN_O(oc_en));

	tmr_host_model #(.ACK_DELAY(4)) HOST (.clk_i(clk), .service_en_i(service_en),
		.ovf_irq_i(ovf_irq), .cmp_irq_i(cmp_irq), .rdata_i(rdata), .req_o(req),
		.ovf_ack_o(ovf_ack), .cmp_ack_o(cmp_ack));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========
	// Shared tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		HOST.rd_reg(a, d);
		chk(d, exp, what);
	endtask

	task automatic ctl(input logic [1:0] wgm, input logic [2:0] cs, input logic [1:0] com);
		HOST.wr_reg(tmr_pkg::ADDR_CONTROL, {1'b0, com, cs, wgm});
		rd_chk(tmr_pkg::ADDR_CONTROL, {1'b0, com, cs, wgm}, "control");
	endtask

	task automatic step(input int n);
		repeat (n) begin
			@(posedge clk);
			ext_pin <= 1'b1;
			repeat (6) @(posedge clk);
			ext_pin <= 1'b0;
			repeat (6) @(posedge clk);
		end
	endtask

	task automatic wait_irq(input logic ovf, input logic val);
		int n;
		n = 0;
		while ((ovf ? ovf_irq : cmp_irq) !== val && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk({7'h0, ovf ? ovf_irq : cmp_irq}, {7'h0, val}, "request");
	endtask

	task automatic force_out(input logic [1:0] com, input logic exp);
		ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::CS_STOP, com);
		HOST.wr_reg(tmr_pkg::ADDR_FORCE, 8'h01);
		repeat (4) @(posedge clk);
		chk({7'h0, oc_out}, {7'h0, exp}, "forced output");
	endtask

	// ==========
	// Scenarios
	task automatic t_count();
		for (int a = 0; a < 8; a++) begin
			rd_chk(a[2:0], 8'h00, "reset value");
		end
		ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::CS_STOP, tmr_pkg::COM_NONE);
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'h55);
		step(2);
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'h55, "stopped");
		ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::CS_EXT_RISE, tmr_pkg::COM_NONE);
		step(2);
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'h57, "rising edges");
		ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::CS_EXT_FALL, tmr_pkg::COM_NONE);
		step(1);
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'h58, "falling edge");
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'hFE);
		step(2);
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'h00, "wrap");
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h01, "overflow flag");
		HOST.wr_reg(tmr_pkg::ADDR_FLAGS, 8'h01);
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h00, "flag cleared");
	endtask

	task automatic t_match();
		HOST.wr_reg(tmr_pkg::ADDR_COMPARE, 8'h10);
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'h10);
		step(1);
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h00, "blocked match");
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'h0F);
		step(2);
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h02, "compare flag");
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'h11, "counted up");
		HOST.wr_reg(tmr_pkg::ADDR_FLAGS, 8'h02);
	endtask

	task automatic t_wave();
		force_out(tmr_pkg::COM_SET, 1'b1);
		force_out(tmr_pkg::COM_NONE, 1'b1);
		force_out(tmr_pkg::COM_CLEAR, 1'b0);
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h00, "no flag on force");
		ctl(tmr_pkg::WGM_CLEAR_ON_MATCH, tmr_pkg::CS_EXT_RISE, tmr_pkg::COM_TOGGLE);
		HOST.wr_reg(tmr_pkg::ADDR_COMPARE, 8'h03);
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'h00);
		step(4);
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'h00, "cleared at top");
		chk({7'h0, oc_out}, 8'h01, "toggled");
		force_out(tmr_pkg::COM_SET, 1'b1);
		HOST.wr_reg(tmr_pkg::ADDR_COMPARE, 8'h22);
		ctl(tmr_pkg::WGM_FAST_PWM, tmr_pkg::CS_EXT_RISE, tmr_pkg::COM_CLEAR);
		chk({7'h0, oc_out}, 8'h01, "kept over mode change");
		HOST.wr_reg(tmr_pkg::ADDR_COMPARE, 8'h80);
		rd_chk(tmr_pkg::ADDR_COMPARE, 8'h80, "buffer");
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'h21);
		HOST.wr_reg(tmr_pkg::ADDR_FLAGS, 8'h03);
		step(2);
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h02, "old working value");
		chk({7'h0, oc_out}, 8'h00, "cleared on match");
		ctl(tmr_pkg::WGM_PHASE_PWM, tmr_pkg::CS_EXT_RISE, tmr_pkg::COM_NONE);
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'hFE);
		step(2);
		rd_chk(tmr_pkg::ADDR_COUNTER, 8'hFE, "turned at max");
	endtask

	task automatic t_irq();
		ctl(tmr_pkg::WGM_NORMAL, tmr_pkg::CS_EXT_RISE, tmr_pkg::COM_NONE);
		HOST.wr_reg(tmr_pkg::ADDR_COMPARE, 8'h05);
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'h04);
		HOST.wr_reg(tmr_pkg::ADDR_MASK, 8'h03);
		HOST.wr_reg(tmr_pkg::ADDR_FLAGS, 8'h03);
		global_en <= 1'b1;
		step(2);
		wait_irq(1'b0, 1'b1);
		global_en <= 1'b0;
		wait_irq(1'b0, 1'b0);
		global_en <= 1'b1;
		service_en <= 1'b1;
		wait_irq(1'b0, 1'b1);
		wait_irq(1'b0, 1'b0);
		rd_chk(tmr_pkg::ADDR_FLAGS, 8'h00, "serviced");
		service_en <= 1'b0;
		HOST.wr_reg(tmr_pkg::ADDR_COUNTER, 8'hFF);
		step(1);
		wait_irq(1'b1, 1'b1);
		service_en <= 1'b1;
		wait_irq(1'b1, 1'b0);
	endtask

	task automatic complete_run();
		$display("checks %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		#(40 * 20000);
		failures++;
		complete_run();
	end

	initial begin
		reset_n = 1'b0;
		ext_pin = 1'b0;
		global_en = 1'b0;
		service_en = 1'b0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_count();
		t_match();
		t_wave();
		t_irq();
		complete_run();
	end
endmodule // tmr_timer8_tb_top

`default_nettype wire
